// >>> design/flash_host_pkg.sv
package flash_host_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int CLK_NS     = 10;   // clock period in ns
    localparam int WP_NS      = 90;   // least write pulse width
    localparam int WPH_NS     = 100;  // least write pulse high width
    localparam int ACC_NS     = 150;  // slowest address/ce access time
    localparam int OEHP_NS    = 150;  // least oe high pulse when toggling
    localparam int BLC_US     = 150;  // longest byte load cycle time
    localparam int WC_MS      = 10;   // longest write cycle time
    localparam int SYNC_STAGES = 2;   // depth of the data-pin synchroniser

    // least times and the access time round up, longest cycle times round down
    localparam int WP_CYC   = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC  = (WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC  = (ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
    localparam int OEHP_CYC = (OEHP_NS + CLK_NS - 1) / CLK_NS;
    localparam int BLC_CYC  = (BLC_US * 1000) / CLK_NS;
    localparam int WC_CYC   = (WC_MS * 1000000) / CLK_NS;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int ADDR_W      = 17;  // byte address width
    localparam int CMD_ADDR_W  = 15;  // command address width
    localparam int SECTOR_LSB  = 7;   // lowest sector address bit
    localparam int DATA_W      = 8;
    localparam int TIMER_W     = 20;
    localparam int BIT_DONE    = 7;   // polarity-polled data bit
    localparam int BIT_TOGGLE  = 6;   // toggling status bit
    localparam logic [7:0] LAST_BYTE = 8'h7F;  // index of last sector byte
    localparam logic [1:0] LAST_STEP = 2'h2;   // last step of a prefix

    // ****************************************************************
    // operation codes on the user command port
    // ****************************************************************
    localparam logic [3:0] OP_READ      = 4'h0;  // plain read
    localparam logic [3:0] OP_PROGRAM   = 4'h1;  // load sector, poll
    localparam logic [3:0] OP_PROT_ON   = 4'h2;  // prefix, load, poll
    localparam logic [3:0] OP_PROT_OFF  = 4'h3;  // prefix, poll
    localparam logic [3:0] OP_ID_ENTRY  = 4'h4;  // prefix only
    localparam logic [3:0] OP_ID_EXIT   = 4'h5;  // prefix only
    localparam logic [3:0] OP_LOCK_LOW  = 4'h6;  // prefix, poll
    localparam logic [3:0] OP_LOCK_HIGH = 4'h7;  // prefix, poll
    localparam logic [3:0] OP_ID_READ   = 4'h8;  // read id byte

    // ****************************************************************
    // sequencer states and phases
    // ****************************************************************
    typedef enum logic [5:0] {
        ST_IDLE      = 6'b00_0001,
        ST_WR_LOW    = 6'b00_0010,
        ST_WR_HIGH   = 6'b00_0100,
        ST_RD_LOW    = 6'b00_1000,
        ST_RD_HIGH   = 6'b01_0000,
        ST_LOAD_WAIT = 6'b10_0000
    } state_type;

    typedef enum logic [3:0] {
        PH_PREFIX = 4'b0001,
        PH_LOAD   = 4'b0010,
        PH_POLL   = 4'b0100,
        PH_READ   = 4'b1000
    } phase_type;

endpackage

// >>> design/sector_flash_write_control.sv
`timescale 1ns/1ps

// What this block does
// - keep sector address fixed across all byte loads
// - start each byte load within byte load window
// - protection enable: prefix, full sector, then poll
// - keep one address for a polling sequence
module sector_flash_write_control
    import flash_host_pkg::*;
#(
    parameter int BLC_CYCLES = BLC_CYC,  // byte load window in cycles
    parameter int WC_CYCLES  = WC_CYC,   // write cycle timeout in cycles
    parameter logic [14:0] UNLOCK_ADDR_A = 15'h0001,
    parameter logic [7:0]  UNLOCK_DATA_A = 8'h01,
    parameter logic [14:0] UNLOCK_ADDR_B = 15'h0002,
    parameter logic [7:0]  UNLOCK_DATA_B = 8'h02,
    parameter logic [14:0] COMMAND_ADDR  = 15'h0001,
    parameter logic [7:0]  CODE_PROT_ON  = 8'h10,
    parameter logic [7:0]  CODE_PROT_OFF = 8'h11,
    parameter logic [7:0]  CODE_ID_ENTRY = 8'h12,
    parameter logic [7:0]  CODE_ID_EXIT  = 8'h13,
    parameter logic [7:0]  CODE_LOCK_LOW = 8'h14,
    parameter logic [7:0]  CODE_LOCK_HI  = 8'h15
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    // user command port
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire logic [3:0]        cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    // user sector byte stream
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              wr_last,
    // results
    output logic                   done,
    output logic [DATA_W-1:0]      rd_data,
    output logic                   late_err,
    output logic                   timeout_err,
    // flash pins
    output logic                   ce_b,
    output logic                   oe_b,
    output logic                   we_b,
    output logic [ADDR_W-1:0]      flash_addr,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe_b
);
    // ****************************************************************
    // state record
    // ****************************************************************
    typedef struct packed {
        state_type            state;      // pin sequencer state
        phase_type            phase;      // what the sequence is doing
        logic [3:0]           op;         // operation being run
        logic [1:0]           step;       // prefix write index
        logic [7:0]           cnt;        // bytes loaded so far
        logic [TIMER_W-1:0]   timer;      // pulse width counter
        logic [TIMER_W-1:0]   wtimer;     // window / timeout counter
        logic [9:0]           sector;     // latched sector address
        logic [DATA_W-1:0]    last_data;  // last loaded byte
        logic                 have_prev;  // first poll read taken
        logic                 prev_t;     // previous toggle bit
        logic [DATA_W-1:0]    dq_s1;      // synchroniser first stage
        logic [DATA_W-1:0]    dq_s2;      // synchroniser second stage
        logic                 done;
        logic [DATA_W-1:0]    rd_data;
        logic                 late_err;
        logic                 timeout_err;
        logic                 ce_b;
        logic                 oe_b;
        logic                 we_b;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    dq_out;
        logic                 dq_oe_b;
    } regs_type;
    regs_type r;       // registered state
    regs_type next_r;  // next state
    localparam logic [TIMER_W-1:0] WP_T   = TIMER_W'(WP_CYC);
    localparam logic [TIMER_W-1:0] WPH_T  = TIMER_W'(WPH_CYC);
    localparam logic [TIMER_W-1:0] ACC_T  = TIMER_W'(ACC_CYC);
    localparam logic [TIMER_W-1:0] OEHP_T = TIMER_W'(OEHP_CYC);
    localparam logic [TIMER_W-1:0] BLC_T  = TIMER_W'(BLC_CYCLES);
    localparam logic [TIMER_W-1:0] WC_T   = TIMER_W'(WC_CYCLES);
    // ****************************************************************
    // helpers
    // ****************************************************************
    // command byte of the third prefix write
    function automatic logic [7:0] op_code(input logic [3:0] op);
        unique case (op)
            OP_PROT_ON:   op_code = CODE_PROT_ON;
            OP_PROT_OFF:  op_code = CODE_PROT_OFF;
            OP_ID_ENTRY:  op_code = CODE_ID_ENTRY;
            OP_ID_EXIT:   op_code = CODE_ID_EXIT;
            OP_LOCK_LOW:  op_code = CODE_LOCK_LOW;
            OP_LOCK_HIGH: op_code = CODE_LOCK_HI;
            default:      op_code = 8'h00;
        endcase
    endfunction
    // prefix address, upper two lines held low
    function automatic logic [ADDR_W-1:0] pre_addr(input logic [1:0] s);
        logic [CMD_ADDR_W-1:0] a;
        a = (s == 2'h0) ? UNLOCK_ADDR_A :
            (s == 2'h1) ? UNLOCK_ADDR_B : COMMAND_ADDR;
        pre_addr = {2'b00, a};
    endfunction
    // whether an op runs a prefix at all
    function automatic logic has_prefix(input logic [3:0] op);
        has_prefix = (op != OP_READ) && (op != OP_PROGRAM) &&
                     (op != OP_ID_READ);
    endfunction
    assign cmd_ready = (r.state == ST_IDLE);
    assign wr_ready  = (r.state == ST_LOAD_WAIT);
    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_r       = r;
        next_r.done  = 1'b0;
        next_r.dq_s1 = dq_in;
        next_r.dq_s2 = r.dq_s1;
        next_r.timer = (r.timer != '0) ? r.timer - 1'b1 : r.timer;
        next_r.wtimer = r.wtimer + 1'b1;
        unique case (r.state)
            ST_IDLE: begin
                next_r.wtimer = '0;
                if (cmd_valid) begin
                    next_r.op        = cmd_op;
                    next_r.sector    = cmd_addr[ADDR_W-1:SECTOR_LSB];
                    next_r.step      = 2'h0;
                    next_r.cnt       = 8'h00;
                    next_r.have_prev = 1'b0;
                    next_r.late_err  = 1'b0;
                    next_r.timeout_err = 1'b0;
                    if (has_prefix(cmd_op)) begin
                        next_r.phase  = PH_PREFIX;  // first unlock write
                        next_r.state  = ST_WR_LOW;
                        next_r.timer  = WP_T;
                        next_r.addr   = pre_addr(2'h0);
                        next_r.dq_out = UNLOCK_DATA_A;
                    end else if (cmd_op == OP_PROGRAM) begin
                        next_r.phase = PH_LOAD;
                        next_r.state = ST_LOAD_WAIT;
                    end else begin
                        next_r.phase = PH_READ;  // plain or id read
                        next_r.state = ST_RD_LOW;
                        next_r.timer = ACC_T;
                        next_r.addr  = (cmd_op == OP_ID_READ) ?
                            {{(ADDR_W-1){1'b0}}, cmd_addr[0]} :
                            cmd_addr;
                    end
                end
            end
            ST_LOAD_WAIT: begin
                if (wr_valid) begin
                    // same sector for every byte of the load
                    next_r.addr = {r.sector, r.cnt[6:0]};
                    next_r.dq_out    = wr_data;
                    next_r.last_data = wr_data;
                    next_r.state     = ST_WR_LOW;
                    next_r.timer     = WP_T;
                    if ((wr_last && r.op != OP_PROT_ON) ||
                        r.cnt == LAST_BYTE) begin
                        // short load leaves the rest undefined
                        next_r.cnt = LAST_BYTE;
                    end
                end else if (r.wtimer >= BLC_T) begin
                    // window lost: device has started programming
                    next_r.late_err = 1'b1;
                    next_r.phase    = PH_POLL;
                    next_r.state    = ST_RD_LOW;
                    next_r.timer    = ACC_T;
                    next_r.wtimer   = '0;
                end
            end
            ST_WR_LOW: begin
                if (r.timer == '0) begin
                    next_r.state = ST_WR_HIGH;
                    next_r.timer = WPH_T;
                end
            end
            ST_WR_HIGH: begin
                if (r.timer == '0) begin
                    if (r.phase == PH_PREFIX && r.step != LAST_STEP) begin
                        next_r.step   = r.step + 1'b1;  // next prefix write
                        next_r.addr   = pre_addr(r.step + 1'b1);
                        next_r.dq_out = (r.step == 2'h0) ?
                            UNLOCK_DATA_B : op_code(r.op);
                        next_r.state  = ST_WR_LOW;
                        next_r.timer  = WP_T;
                    end else if (r.phase == PH_PREFIX &&
                                 r.op == OP_PROT_ON) begin
                        // full sector must follow the enable
                        next_r.phase  = PH_LOAD;
                        next_r.state  = ST_LOAD_WAIT;
                        next_r.wtimer = '0;
                    end else if (r.phase == PH_PREFIX &&
                                 (r.op == OP_ID_ENTRY ||
                                  r.op == OP_ID_EXIT)) begin
                        // mode change only, nothing to poll
                        next_r.state = ST_IDLE;
                        next_r.done  = 1'b1;
                    end else if (r.phase == PH_LOAD &&
                                 r.cnt != LAST_BYTE) begin
                        next_r.cnt    = r.cnt + 1'b1;  // window restarts
                        next_r.state  = ST_LOAD_WAIT;
                        next_r.wtimer = '0;
                    end else begin
                        next_r.phase  = PH_POLL;
                        next_r.state  = ST_RD_LOW;  // program running: poll
                        next_r.timer  = ACC_T;
                        next_r.wtimer = '0;
                    end
                end
            end
            ST_RD_LOW: begin
                if (r.timer == '0) begin
                    next_r.state   = ST_RD_HIGH;
                    next_r.timer   = OEHP_T;
                    next_r.rd_data = r.dq_s2;
                end
            end
            ST_RD_HIGH: begin
                if (r.timer == '0) begin
                    if (r.phase == PH_READ) begin
                        next_r.state = ST_IDLE;
                        next_r.done  = 1'b1;
                    end else if (r.have_prev &&
                        r.prev_t == r.rd_data[BIT_TOGGLE] &&
                        (r.op != OP_PROGRAM && r.op != OP_PROT_ON ||
                         r.rd_data[BIT_DONE] ==
                         r.last_data[BIT_DONE])) begin
                        // toggling stopped, and for program or protection enable true data back
                        next_r.state = ST_IDLE;
                        next_r.done  = 1'b1;
                    end else if (r.wtimer >= WC_T) begin
                        next_r.timeout_err = 1'b1;
                        next_r.state       = ST_IDLE;
                        next_r.done        = 1'b1;
                    end else begin
                        // another strobe on oe, same address
                        next_r.have_prev = 1'b1;
                        next_r.prev_t    = r.rd_data[BIT_TOGGLE];
                        next_r.state     = ST_RD_LOW;
                        next_r.timer     = ACC_T;
                    end
                end
            end
            default: begin
                next_r.state = ST_IDLE;
            end
        endcase
        // pins follow the next state, registered
        next_r.ce_b    = (next_r.state == ST_IDLE);
        next_r.we_b    = (next_r.state != ST_WR_LOW);
        next_r.oe_b    = (next_r.state != ST_RD_LOW);
        next_r.dq_oe_b = !(next_r.state == ST_WR_LOW ||
                           next_r.state == ST_WR_HIGH);
    end
    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r         <= '0;
            r.state   <= ST_IDLE;
            r.phase   <= PH_READ;
            r.ce_b    <= 1'b1;
            r.oe_b    <= 1'b1;
            r.we_b    <= 1'b1;
            r.dq_oe_b <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
    assign done        = r.done;
    assign rd_data     = r.rd_data;
    assign late_err    = r.late_err;
    assign timeout_err = r.timeout_err;
    assign ce_b        = r.ce_b;
    assign oe_b        = r.oe_b;
    assign we_b        = r.we_b;
    assign flash_addr  = r.addr;
    assign dq_out      = r.dq_out;
    assign dq_oe_b     = r.dq_oe_b;
endmodule

// >>> tb/flash_host_chk.sv
`timescale 1ns/1ps

// ****************************************************************
// pin protocol checks of the flash host
// ****************************************************************
module flash_host_chk
    import flash_host_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              cmd_ready,
    input wire logic              wr_ready,
    input wire logic              done,
    input wire logic              ce_b,
    input wire logic              oe_b,
    input wire logic              we_b,
    input wire logic [ADDR_W-1:0] flash_addr,
    input wire logic              dq_oe_b
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // write strobe low for the least pulse width of nine cycles
    sequence we_low_nine;
        (!we_b)[*8] ##1 !we_b;
    endsequence
    // output enable high for fifteen cycles between polling reads
    sequence oe_high_fifteen;
        oe_b[*8] ##1 oe_b[*7];
    endsequence

    reset_quiet_a: assert property ($rose(rst_b) |-> ce_b && we_b && oe_b)
        else $error("strobes active after reset");
    write_pulse_a: assert property ($fell(we_b) |-> we_low_nine)
        else $error("write pulse shorter than nine cycles");
    write_drive_a: assert property (!we_b |-> oe_b && !ce_b && !dq_oe_b)
        else $error("write strobe without chip select or drive");
    load_addr_a: assert property (!we_b && $past(!we_b) |-> $stable(flash_addr))
        else $error("address moved during write pulse");
    poll_addr_a: assert property (!oe_b && $past(!oe_b) |-> $stable(flash_addr))
        else $error("address moved during read");
    toggle_gap_a: assert property ($rose(oe_b) && !ce_b |-> oe_high_fifteen)
        else $error("oe high pulse too short");
    done_pulse_a: assert property (done |=> !done)
        else $error("done longer than one cycle");
    idle_quiet_a: assert property (cmd_ready |-> ce_b && we_b && oe_b)
        else $error("flash strobes active while idle");
    load_wait_a: assert property (wr_ready |-> we_b && oe_b && dq_oe_b)
        else $error("bus busy while waiting for a byte");
endmodule

bind sector_flash_write_control flash_host_chk u_chk (
    .clk        (clk),
    .rst_b      (rst_b),
    .cmd_ready  (cmd_ready),
    .wr_ready   (wr_ready),
    .done       (done),
    .ce_b       (ce_b),
    .oe_b       (oe_b),
    .we_b       (we_b),
    .flash_addr (flash_addr),
    .dq_oe_b    (dq_oe_b)
);

// >>> tb/flash_model.sv
`timescale 1ns/1ps

// ****************************************************************
// behavioural sector flash on the host pins
// ****************************************************************
module flash_model #(
    parameter int         LOAD_NS = 1000,   // byte load window
    parameter int         PROG_NS = 5000,   // internal program time
    parameter int         BOOT    = 8192,   // boot block size
    parameter logic [7:0] MAKER   = 8'h3C,  // arbitrary maker code
    parameter logic [7:0] PART    = 8'hC3   // arbitrary part code
) (
    input wire logic        ce_b,
    input wire logic        oe_b,
    input wire logic        we_b,
    input wire logic [16:0] flash_addr,
    input wire logic [7:0]  dq_out,
    output logic [7:0]      dq_in
);
    logic [7:0] mem [int];       // programmed bytes, absent = erased
    logic [7:0] stage [int];     // latched sector bytes
    logic [1:0] step = 2'h0;     // prefix progress
    logic       id_mode = 1'h0;
    logic       prot = 1'h0;
    logic       arm = 1'h0;
    logic       prot_set = 1'h0;
    logic       prot_clr = 1'h0;
    logic       lock_lo = 1'h0;
    logic       lock_hi = 1'h0;
    logic       pend = 1'h0;     // load or program in progress
    logic       busy = 1'h0;
    logic       tog = 1'h0;
    logic       b7 = 1'h0;       // last loaded top data bit
    logic [7:0] last_v = 8'h00;
    time        last_t = 0;
    int         i;

    // one write strobe: prefix step, command or byte load
    task automatic load(input logic [16:0] a, input logic [7:0] d);
        if (busy) return;
        if (step == 2'h0 && a[14:0] == 15'h0001 && d == 8'h01) step = 2'h1;
        else if (step == 2'h1 && a[14:0] == 15'h0002 && d == 8'h02) step = 2'h2;
        else if (step == 2'h2 && a[14:0] == 15'h0001) begin
            step = 2'h0;
            case (d)
                8'h10: begin arm = 1'h1; prot_set = 1'h1; end
                8'h11: begin prot_clr = 1'h1; pend = 1'h1; end
                8'h12: id_mode = 1'h1;
                8'h13: id_mode = 1'h0;
                8'h14: begin lock_lo = 1'h1; pend = 1'h1; end
                8'h15: begin lock_hi = 1'h1; pend = 1'h1; end
                default: ;
            endcase
            last_t = $time;
        end else begin
            step = 2'h0;
            if ((!prot || arm) && !(lock_lo && a < BOOT)
                && !(lock_hi && a >= 131072 - BOOT)) begin
                stage[a] = d;
                b7 = d[7];
                pend = 1'h1;
                last_t = $time;
            end
        end
    endtask

    // bytes latch on the rising write strobe
    always @(posedge we_b) begin
        if (!ce_b) load(flash_addr, dq_out);
    end

    // program after the load window, unloaded bytes garbage
    always #10 begin
        if (pend && !busy && $time - last_t >= LOAD_NS) begin
            busy = 1'h1;
            #PROG_NS;
            foreach (stage[k]) i = k & ~127;
            for (int j = 0; j < 128 && stage.num() > 0; j++) begin
                mem[i+j] = stage.exists(i+j) ? stage[i+j] : ~8'(i+j);
            end
            if (prot_set) prot = 1'h1;
            if (prot_clr) prot = 1'h0;
            {arm, prot_set, prot_clr} = 3'h0;
            stage.delete();
            busy = 1'h0;
            pend = 1'h0;
        end
    end

    // each read strobe advances the toggle bit
    always @(negedge oe_b or negedge ce_b) begin
        if (!ce_b && !oe_b) tog = ~tog;
    end

    // read data, inverse of last value once released
    always #1 begin
        if (!ce_b && !oe_b) begin
            if (id_mode && flash_addr[16:1] == 16'h0000)
                last_v = flash_addr[0] ? PART : MAKER;
            else if (pend) last_v = {~b7, tog, 6'h00};
            else if (mem.exists(flash_addr)) last_v = mem[flash_addr];
            else last_v = 8'hFF;
            dq_in = last_v;
        end else dq_in = ~last_v;
    end
endmodule

// >>> tb/sector_flash_write_control_bench.sv
`timescale 1ns/1ps

// ****************************************************************
// random sector traffic against the flash model
// ****************************************************************
module sector_flash_write_control_bench
    import flash_host_pkg::*;
;
    logic              clk = 1'h0;
    logic              rst_b = 1'h0;
    logic              cmd_valid = 1'h0;
    logic [3:0]        cmd_op = 4'h0;
    logic [ADDR_W-1:0] cmd_addr = 17'h0_0000;
    logic              wr_valid = 1'h0;
    logic [7:0]        wr_data = 8'h00;
    logic              wr_last = 1'h0;
    logic              cmd_ready, wr_ready, done, late_err, timeout_err;
    logic              ce_b, oe_b, we_b, dq_oe_b;
    logic [16:0]       flash_addr, sec;
    logic [7:0]        dq_in, dq_out, rd_data;
    logic [7:0]        exp [int];  // expected flash contents
    int                err_count = 0;
    int                num_checks = 0;

    always #5 clk = ~clk;

    sector_flash_write_control #(.BLC_CYCLES(50), .WC_CYCLES(2000)) u_dut (
        .clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .wr_last(wr_last), .done(done), .rd_data(rd_data),
        .late_err(late_err), .timeout_err(timeout_err), .ce_b(ce_b),
        .oe_b(oe_b), .we_b(we_b), .flash_addr(flash_addr),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_b(dq_oe_b));

    flash_model u_flash (.ce_b(ce_b), .oe_b(oe_b), .we_b(we_b),
        .flash_addr(flash_addr), .dq_out(dq_out), .dq_in(dq_in));

    // byte pattern, bit six set so no byte looks like a prefix
    function automatic logic [7:0] dat(input logic [16:0] a, logic [7:0] s);
        return (a[7:0] * 8'h1D ^ s) | 8'h40;
    endfunction

    // verdict and end of run
    task automatic end_of_test();
        if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // one compare
    task automatic chk(input string n, logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask

    // one command with n sector bytes, then wait for done
    task automatic run(input logic [3:0] op, logic [16:0] a, int n,
                       logic last, logic [7:0] s, logic upd);
        int k;
        @(posedge clk);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_valid <= 1'h1;
        @(posedge clk);
        cmd_valid <= 1'h0;
        for (int i = 0; i < n; i++) begin
            wr_valid <= 1'h1;
            wr_data <= dat(a + 17'(i), s);
            wr_last <= last && i == n - 1;
            k = 0;
            do begin @(negedge clk); k++; end while (!wr_ready && k < 300);
            if (k == 300) begin err_count++; end_of_test(); end
            @(posedge clk);
            if (upd) exp[a + i] = dat(a + 17'(i), s);
        end
        wr_valid <= 1'h0;
        wr_last <= 1'h0;
        k = 0;
        do begin @(negedge clk); k++; end while (done !== 1'h1 && k < 9000);
        if (k == 9000) begin err_count++; end_of_test(); end
    endtask

    // read back and compare, unwritten bytes read erased
    task automatic rd(input logic [16:0] a);
        run(OP_READ, a, 0, 1'h0, 8'h00, 1'h0);
        chk("rd_data", exp.exists(a) ? exp[a] : 8'hFF, rd_data);
    endtask

    initial begin
        void'($urandom(92470));
        repeat (6) @(posedge clk);
        rst_b <= 1'h1;
        sec = 17'h0_4000 + 17'(($urandom % 64) << 7);
        run(OP_PROGRAM, sec, 128, 1'h0, 8'($urandom), 1'h1);
        chk("late_err", 8'h00, {7'h0, late_err});
        chk("timeout_err", 8'h00, {7'h0, timeout_err});
        rd(sec);
        rd(sec + 17'h7F);
        repeat (4) rd(sec + 17'($urandom % 128));
        run(OP_PROGRAM, sec + 17'h80, 5, 1'h1, 8'($urandom), 1'h1);
        for (int i = 0; i < 5; i++) rd(sec + 17'h80 + 17'(i));
        run(OP_PROGRAM, sec + 17'h100, 3, 1'h0, 8'($urandom), 1'h1);
        chk("late_err", 8'h01, {7'h0, late_err});
        rd(sec + 17'h102);
        run(OP_ID_ENTRY, 17'h0, 0, 1'h0, 8'h00, 1'h0);
        run(OP_ID_READ, 17'h0, 0, 1'h0, 8'h00, 1'h0);
        chk("maker", 8'h3C, rd_data);
        run(OP_ID_READ, 17'h1, 0, 1'h0, 8'h00, 1'h0);
        chk("part", 8'hC3, rd_data);
        run(OP_ID_EXIT, 17'h0, 0, 1'h0, 8'h00, 1'h0);
        rd(sec + 17'h1);
        run(OP_PROT_ON, sec + 17'h200, 128, 1'h0, 8'($urandom), 1'h1);
        run(OP_PROGRAM, sec + 17'h200, 128, 1'h0, 8'($urandom), 1'h0);
        rd(sec + 17'h205);
        run(OP_PROT_OFF, 17'h0, 0, 1'h0, 8'h00, 1'h0);
        run(OP_PROGRAM, sec + 17'h200, 128, 1'h0, 8'($urandom), 1'h1);
        chk("timeout_err", 8'h00, {7'h0, timeout_err});
        rd(sec + 17'h209);
        run(OP_LOCK_LOW, 17'h0, 0, 1'h0, 8'h00, 1'h0);
        run(OP_PROGRAM, 17'h0_0080, 4, 1'h1, 8'($urandom), 1'h0);
        rd(17'h0_0081);
        run(OP_LOCK_HIGH, 17'h0, 0, 1'h0, 8'h00, 1'h0);
        run(OP_PROGRAM, 17'h1_FF00, 4, 1'h1, 8'($urandom), 1'h0);
        rd(17'h1_FF01);
        end_of_test();
    end
endmodule
